//--- dv/ilv_bp_model.sv
`timescale 1ns/1ps
// ------------------------------
// backplane and pin side model
// ------------------------------
module ilv_bp_model (
   // clock
   input wire        clock,
   // block pin drivers
   input wire [3:0]  gp_pin_out,
   input wire [3:0]  gp_pin_oe,
   // backplane lines
   output reg        acfail_active,
   output reg        sysfail_active,
   output reg        abort_active,
   output reg [6:0]  bp_req,
   output reg        spare_req,
   output reg        bgin_raw,
   output reg        bp_won,
   output reg        local_retried,
   output reg        as_active,
   // pins
   output wire [3:0] gp_pin_in,
   output reg [7:0]  gp_input_pins
);
   // undriven pins float up through pull-ups, never to a stale value
   assign gp_pin_in = (gp_pin_oe & gp_pin_out) | ~gp_pin_oe;
   // quiet backplane at start
   initial begin
      {acfail_active, sysfail_active, abort_active, bgin_raw} = 4'h0;
      {spare_req, bp_req} = 8'h00;
      {bp_won, local_retried, as_active} = 3'h0;
      gp_input_pins = 8'hA5;
   end
   // one-cycle request, spare in bit 7
   task req_pulse(input [7:0] sel);
      begin
         @(posedge clock);
         {spare_req, bp_req} <= sel;
         @(posedge clock);
         {spare_req, bp_req} <= 8'h00;
      end
   endtask
   // bus won while the local master is retried
   task win_retried;
      begin
         @(posedge clock);
         {bp_won, local_retried} <= 2'h3;
         @(posedge clock);
         {bp_won, local_retried} <= 2'h0;
      end
   endtask
   // grant line high for n cycles
   task bgin_hold(input integer n);
      begin
         @(posedge clock);
         bgin_raw <= 1'b1;
         repeat (n) @(posedge clock);
         bgin_raw <= 1'b0;
      end
   endtask
endmodule // ilv_bp_model

//--- dv/ilv_chk_asserts.sv
`timescale 1ns/1ps
// ------------------------------
// bus and output checks
// ------------------------------
module ilv_chk (
   // clock and resets
   input wire        clock,
   input wire        rst,
   input wire        sys_reset,
   input wire        local_reset,
   // bus
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire        hreadyout,
   // lines and outputs
   input wire        bgin_raw,
   input wire        bgin_clean,
   input wire        bp_won,
   input wire        local_retried,
   input wire        bbsy_drive,
   input wire [3:0]  gp_pin_out,
   input wire [3:0]  gp_pin_oe,
   input wire        irq,
   input wire [2:0]  local_level,
   input wire [3:0]  vector_base_zero,
   input wire [3:0]  vector_base_one
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   reg  wr_ff;                              // write in data phase
   reg  io_ff;                              // that phase aims at 0x88
   wire take  = hsel & htrans[1] & hready;  // address phase taken
   wire io_wr = wr_ff & io_ff;
   // follow the data phase; a stalled phase keeps its state
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_ff <= 1'b0;
         io_ff <= 1'b0;
      end else if (hready) begin
         wr_ff <= take & hwrite;
         io_ff <= haddr[7:2] == 6'h22;
      end
   end
   property p_wr_nowait; wr_ff |-> hreadyout; endproperty
   a_wr_nowait: assert property (p_wr_nowait) else $error("write phase stalled");
   property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   property p_busy_min; bp_won && local_retried |=> bbsy_drive [*3]; endproperty
   a_busy_min: assert property (p_busy_min) else $error("busy hold too short");
   property p_lvl_gate; local_level != 3'h0 |-> $past(irq); endproperty
   a_lvl_gate: assert property (p_lvl_gate) else $error("level without irq");
   property p_unmask; !irq |=> local_level == 3'h0; endproperty
   a_unmask: assert property (p_unmask) else $error("level while masked");
   property p_filter; $changed(bgin_clean) |-> bgin_clean == bgin_raw; endproperty
   a_filter: assert property (p_filter) else $error("grant output glitch");
   property p_dir_hold; $changed(gp_pin_oe) |-> $past(io_wr || sys_reset); endproperty
   a_dir_hold: assert property (p_dir_hold) else $error("direction changed");
   property p_drv_hold;
      $changed(gp_pin_out[2:0]) |-> $past(io_wr || sys_reset);
   endproperty
   a_drv_hold: assert property (p_drv_hold) else $error("drive changed");
   property p_vec_hold;
      $changed({vector_base_zero, vector_base_one}) |-> $past(io_wr || sys_reset || local_reset);
   endproperty
   a_vec_hold: assert property (p_vec_hold) else $error("vector changed");
   property p_sys_clr; sys_reset |=> gp_pin_oe == 4'h0 && gp_pin_out == 4'h0; endproperty
   a_sys_clr: assert property (p_sys_clr) else $error("pins kept on reset");
endmodule // ilv_chk
bind ilv_ctl ilv_chk u_chk (.clock(clock), .rst(rst), .sys_reset(sys_reset),
   .local_reset(local_reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .bgin_raw(bgin_raw),
   .bgin_clean(bgin_clean), .bp_won(bp_won), .local_retried(local_retried),
   .bbsy_drive(bbsy_drive), .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe), .irq(irq),
   .local_level(local_level), .vector_base_zero(vector_base_zero),
   .vector_base_one(vector_base_one));

//--- dv/ilv_ctl_tb.sv
`timescale 1ns/1ps
// ------------------------------
// register and line bench
// ------------------------------
module ilv_ctl_tb;
   reg         clock = 1'b0;
   reg         rst = 1'b1;
   reg         sys_reset = 1'b0;
   reg         local_reset = 1'b0;
   reg         hsel = 1'b0;
   reg  [31:0] haddr = 32'h00000000;
   reg  [1:0]  htrans = 2'h0;
   reg         hwrite = 1'b0;
   reg  [2:0]  hsize = 3'h2;
   reg  [31:0] hwdata = 32'h00000000;
   wire        hready, hreadyout, bgin_clean, bbsy_drive, irq;
   wire [31:0] hrdata;
   wire        acfail_active, sysfail_active, abort_active, spare_req;
   wire        bgin_raw, bp_won, local_retried, as_active;
   wire [6:0]  bp_req;
   wire [3:0]  gp_pin_in, gp_pin_out, gp_pin_oe, vector_base_zero, vector_base_one;
   wire [7:0]  gp_input_pins;
   wire [2:0]  local_level;
   integer     err_total = 0;
   integer     total_checks = 0;
   integer     cyc = 0;
   integer     n;
   integer     i;
   reg  [31:0] g;
   assign hready = hreadyout;               // single slave owns ready
   wire [2:0] obs = {irq, bgin_clean, bbsy_drive};
   ilv_ctl uut (.clock(clock), .rst(rst), .sys_reset(sys_reset), .local_reset(local_reset),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
      .acfail_active(acfail_active), .sysfail_active(sysfail_active),
      .abort_active(abort_active), .bp_req(bp_req), .spare_req(spare_req),
      .bgin_raw(bgin_raw), .bgin_clean(bgin_clean), .bp_won(bp_won),
      .local_retried(local_retried), .as_active(as_active), .bbsy_drive(bbsy_drive),
      .gp_pin_in(gp_pin_in), .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe),
      .gp_input_pins(gp_input_pins), .irq(irq), .local_level(local_level),
      .vector_base_zero(vector_base_zero), .vector_base_one(vector_base_one));
   ilv_bp_model m (.clock(clock), .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe),
      .acfail_active(acfail_active), .sysfail_active(sysfail_active),
      .abort_active(abort_active), .bp_req(bp_req), .spare_req(spare_req),
      .bgin_raw(bgin_raw), .bp_won(bp_won), .local_retried(local_retried),
      .as_active(as_active), .gp_pin_in(gp_pin_in), .gp_input_pins(gp_input_pins));
   initial forever #2.5 clock = ~clock;
   task close_out;
      begin
         if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // hang guard, run needs a few hundred cycles
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         close_out;
      end
   end
   task chk(input string nm, input [31:0] e, input [31:0] s);
      begin
         total_checks = total_checks + 1;
         if (s !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, s);
            err_total = err_total + 1;
         end
      end
   endtask
   // ready looked at mid-cycle, where it stands settled until the edge
   task wait_rdy(output [31:0] d);
      reg ok;
      integer k;
      begin
         ok = 1'b0;
         k = 0;
         while (ok !== 1'b1) begin
            @(negedge clock);
            ok = hreadyout;
            d = hrdata;
            @(posedge clock);
            k = k + 1;
            if (k > 50) begin
               err_total = err_total + 1;
               close_out;
            end
         end
      end
   endtask
   task xfer(input w, input [7:0] a, input [31:0] wd, output [31:0] rd);
      reg [31:0] nu;
      begin
         @(posedge clock);
         {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 24'h000000, a};
         wait_rdy(nu);
         {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
         wait_rdy(rd);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      xfer(1'b1, a, d, g);
   endtask
   task rdc(input [7:0] a, input [31:0] e);
      begin
         xfer(1'b0, a, 32'h00000000, g);
         chk($sformatf("reg %h", a), e, g);
      end
   endtask
   // count cycles an observed output is high
   task cnt(input integer w, input integer span);
      begin
         n = 0;
         repeat (span) begin
            @(negedge clock);
            if (obs[w] === 1'b1) n = n + 1;
         end
      end
   endtask
   task pulse(input s);
      begin
         @(posedge clock);
         if (s) sys_reset <= 1'b1;
         else local_reset <= 1'b1;
         @(posedge clock);
         {sys_reset, local_reset} <= 2'h0;
      end
   endtask
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      rdc(8'h80, 32'h00000000);
      rdc(8'h84, 32'h00000000);
      rdc(8'h88, 32'h00000FA5);
      rdc(8'h8C, 32'h00000000);
      wr(8'h80, 32'hFFFFFFFF);
      rdc(8'h80, 32'h00777777);
      wr(8'h84, 32'hF6543210);
      rdc(8'h84, 32'h76543210);
      m.acfail_active <= 1'b1;
      wr(8'h88, 32'hAB8F5000);
      rdc(8'h88, 32'hABAF55A5);
      chk("pins", 16'hABF5, {vector_base_zero, vector_base_one, gp_pin_oe, gp_pin_out});
      {m.acfail_active, m.sysfail_active} <= 2'h1;
      rdc(8'h88, 32'hABCF55A5);
      // software keeps the unused multiprocessor bit clear
      wr(8'h8C, 32'h00000000);
      fork m.win_retried; cnt(0, 40); join
      chk("busy long", 32, n);
      wr(8'h8C, 32'h00000004);
      fork m.win_retried; cnt(0, 40); join
      chk("busy short", 3, n);
      wr(8'h8C, 32'h00000008);
      m.as_active <= 1'b1;
      cnt(0, 3);
      chk("early off", 3, n);
      m.as_active <= 1'b0;
      wr(8'h8C, 32'h00000000);
      fork m.bgin_hold(1); cnt(1, 10); join
      chk("grant glitch", 0, n);
      fork m.bgin_hold(6); cnt(1, 12); join
      chk("grant held", 6, n);
      wr(8'h8C, 32'h00000001);
      fork m.bgin_hold(1); cnt(1, 10); join
      chk("grant bypass", 1, n);
      wr(8'h94, 32'h00003FFF);
      wr(8'h98, 32'h00000001);
      rdc(8'h90, 32'h00000001);
      chk("irq level", 4'hF, {irq, local_level});
      wr(8'h80, 32'h00000003);
      cnt(2, 2);
      chk("irq level", 4'hB, {irq, local_level});
      wr(8'h88, 32'hAB0F5000);
      cnt(2, 2);
      chk("masked all", 4'h0, {irq, local_level});
      wr(8'h88, 32'hAB8F5000);
      wr(8'h94, 32'h00000000);
      cnt(2, 2);
      chk("masked one", 0, n);
      wr(8'h94, 32'h00003FFF);
      wr(8'h90, 32'h00000001);
      rdc(8'h90, 32'h00000000);
      for (i = 0; i < 8; i = i + 1) begin
         m.req_pulse(8'h01 << i);
         cnt(2, 3);
         rdc(8'h90, 32'h00000040 << i);
         chk("req level", i | 8, {irq, local_level});
         wr(8'h90, 32'h00003FFF);
      end
      wr(8'h8C, 32'h00000003);
      m.req_pulse(8'h01);
      rdc(8'h90, 32'h00000000);
      wr(8'h8C, 32'h0000000D);
      wr(8'h9C, 32'hFFFFFFFF);
      rdc(8'h9C, 32'h00000000);
      pulse(1'b0);
      rdc(8'h88, 32'h004F55A5);
      rdc(8'h8C, 32'h0000000D);
      rdc(8'h80, 32'h00000000);
      pulse(1'b1);
      rdc(8'h88, 32'h00400FA5);
      rdc(8'h8C, 32'h00000000);
      close_out;
   end
endmodule // ilv_ctl_tb

//--- verilog/ilv_ctl.v
`timescale 1ns/1ps
`include "ilv_map.vh"
// Notes on behaviour
// - six software level fields, cleared by every reset
// - two 3-bit level fields per byte
// - each backplane request level mapped independently
// - spare level field shares byte with req7
// - two vector base fields in top byte
// - global unmask bit low masks every interrupt
// - read-only acfail line state bit
// - read-only sysfail line state bit
// - four direction bits, cleared power-up and system
// - four read-only pin sense bits
// - four drive bits used when pin outputs
// - read-only byte of eight input pins
// - grant filter off bypasses bus-grant filter
// - irq filter on enables request input filters
// - reset letters honoured per field
// - busy hold 32 or 3 clocks
// - early release off drives busy with strobe
module ilv_ctl (
   // clock and resets
   input  wire        clock,
   input  wire        rst,
   input  wire        sys_reset,
   input  wire        local_reset,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   // backplane status lines
   input  wire        acfail_active,
   input  wire        sysfail_active,
   input  wire        abort_active,
   // interrupt sources
   input  wire [6:0]  bp_req,
   input  wire        spare_req,
   // bus grant and busy
   input  wire        bgin_raw,
   output wire        bgin_clean,
   input  wire        bp_won,
   input  wire        local_retried,
   input  wire        as_active,
   output wire        bbsy_drive,
   // general purpose pins
   input  wire [3:0]  gp_pin_in,
   output wire [3:0]  gp_pin_out,
   output wire [3:0]  gp_pin_oe,
   input  wire [7:0]  gp_input_pins,
   // local interrupt outputs
   output wire        irq,
   output reg  [2:0]  local_level,
   output wire [3:0]  vector_base_zero,
   output wire [3:0]  vector_base_one
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   reg  [23:0] soft_lvl_ff;       // software level fields
   reg  [31:0] bp_lvl_ff;         // backplane and spare level fields
   reg  [7:0]  vec_ff;            // two vector bases
   reg         global_irq_unmask_ff;           // global_irq_unmask
   reg  [3:0]  dir_ff;            // gp_pin_dir
   reg  [3:0]  drive_ff;          // gp_pin_drive
   reg  [7:0]  misc_ff;           // misc bus control byte
   reg  [13:0] stat_ff;           // sticky interrupt status
   reg  [13:0] mask_ff;           // interrupt mask
   reg  [7:0]  req_prev_ff;       // previous filtered request lines
   reg  [5:0]  bsy_cnt_ff;        // busy hold countdown
   reg  [7:0]  addr_ff;           // latched address phase offset
   reg         wr_ff;             // write data phase pending
   reg         rd_ff;             // read data phase pending
   reg  [3:0]  lanes_ff;          // byte lanes of the pending write
   reg  [13:0] nxt_stat;          // next status
   reg  [2:0]  nxt_level;         // next presented level
   reg  [31:0] nxt_rdata;         // read mux output
   wire [7:0]  req_filt;          // filtered request lines
   wire [7:0]  filt_out;          // filter outputs
   wire [7:0]  filt_bypass;       // per line bypass
   wire        take;              // address phase accepted
   wire [31:0] wmask;             // bit mask from byte lanes
   wire [31:0] wdat;              // write data
   wire        wr_soft;           // write strobes per register
   wire        wr_bp;
   wire        wr_vio;
   wire        wr_misc;
   wire        wr_stat;
   wire        wr_mask;
   wire        wr_set;
   wire        clr_psl;           // system or local reset
   wire [13:0] pend;              // pending and enabled sources
   wire [31:0] soft_new;          // merged software level word
   wire [31:0] mask_new;          // merged mask word
   integer     i;

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   // byte lanes touched by an access of this size and address
   function [3:0] ilv_lanes;
      input [2:0] size;
      input [1:0] a;
      begin
         case (size)
            3'h0:    ilv_lanes = 4'h1 << a;
            3'h1:    ilv_lanes = a[1] ? 4'hC : 4'h3;
            default: ilv_lanes = 4'hF;
         endcase
      end
   endfunction

   // merge masked write data into an old value
   function [31:0] ilv_merge;
      input [31:0] old;
      input [31:0] dat;
      input [31:0] m;
      begin
         ilv_merge = (old & ~m) | (dat & m);
      end
   endfunction

   // level field of source n from the two level registers
   function [2:0] ilv_src_lvl;
      input [3:0]  n;
      input [23:0] sl;
      input [31:0] bl;
      begin
         if (n < 4'h6)
            ilv_src_lvl = sl[n*4 +: 3];
         else
            ilv_src_lvl = bl[(n-4'h6)*4 +: 3];
      end
   endfunction

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   assign take      = hsel & htrans[1] & hready;
   assign hresp     = 1'b0;
   // reads take one wait state so data comes from a flop
   assign hreadyout = ~rd_ff;
   assign clr_psl   = sys_reset | local_reset;

   // address phase capture
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         addr_ff  <= `ILV_RST_BYTE;
         wr_ff    <= 1'b0;
         rd_ff    <= 1'b0;
         lanes_ff <= 4'h0;
      end else begin
         rd_ff <= take & ~hwrite;
         wr_ff <= take & hwrite;
         if (take) begin
            addr_ff  <= {haddr[7:2], 2'h0};
            lanes_ff <= ilv_lanes(hsize, haddr[1:0]);
         end
      end
   end

   assign wmask = {{8{lanes_ff[3]}}, {8{lanes_ff[2]}}, {8{lanes_ff[1]}}, {8{lanes_ff[0]}}};
   assign wdat  = hwdata;
   // unmapped writes fall through every strobe and are dropped
   assign wr_soft = wr_ff & (addr_ff == `ILV_OFS_SOFT_LVL);
   assign wr_bp   = wr_ff & (addr_ff == `ILV_OFS_BP_LVL);
   assign wr_vio  = wr_ff & (addr_ff == `ILV_OFS_VEC_IO);
   assign wr_misc = wr_ff & (addr_ff == `ILV_OFS_MISC);
   assign wr_stat = wr_ff & (addr_ff == `ILV_OFS_IRQ_STAT);
   assign wr_mask = wr_ff & (addr_ff == `ILV_OFS_IRQ_MASK);
   assign wr_set  = wr_ff & (addr_ff == `ILV_OFS_SOFT_SET);
   assign soft_new = ilv_merge({8'h00, soft_lvl_ff}, wdat, wmask & `ILV_SOFT_LVL_MASK);
   assign mask_new = ilv_merge({18'h00000, mask_ff}, wdat, wmask);

   // ---------------------------------------------------------------
   // fields cleared by all three resets
   // ---------------------------------------------------------------
   // level fields, vector bases, unmask and mask
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         soft_lvl_ff <= 24'h000000;
         bp_lvl_ff   <= `ILV_RST_WORD;
         vec_ff      <= `ILV_RST_BYTE;
         global_irq_unmask_ff     <= 1'b0;
         mask_ff     <= `ILV_RST_SRC;
      end else if (clr_psl) begin
         soft_lvl_ff <= 24'h000000;
         bp_lvl_ff   <= `ILV_RST_WORD;
         vec_ff      <= `ILV_RST_BYTE;
         global_irq_unmask_ff     <= 1'b0;
         mask_ff     <= `ILV_RST_SRC;
      end else begin
         // only six bits per byte stored
         if (wr_soft)
            soft_lvl_ff <= soft_new[23:0];
         if (wr_bp)
            bp_lvl_ff <= ilv_merge(bp_lvl_ff, wdat, wmask & `ILV_BP_LVL_MASK);
         if (wr_vio & lanes_ff[3])
            vec_ff <= wdat[31:24];
         if (wr_vio & lanes_ff[2])
            global_irq_unmask_ff <= wdat[`ILV_BIT_GLOBAL_IRQ_UNMASK];
         if (wr_mask)
            mask_ff <= mask_new[13:0];
      end
   end

   // ---------------------------------------------------------------
   // fields that survive local reset, except misc bits 7..5 and drive bit 3
   // ---------------------------------------------------------------
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         dir_ff        <= 4'h0;
         drive_ff      <= 4'h0;
         misc_ff       <= `ILV_RST_BYTE;
      end else if (sys_reset) begin
         dir_ff        <= 4'h0;
         drive_ff      <= 4'h0;
         misc_ff       <= `ILV_RST_BYTE;
      end else begin
         if (local_reset)
            misc_ff <= misc_ff & ~`ILV_MISC_PSL_MASK;
         else if (wr_misc & lanes_ff[0])
            misc_ff <= wdat[7:0];
         if (wr_vio & lanes_ff[2])
            dir_ff <= wdat[19:16];
         if (wr_vio & lanes_ff[1])
            drive_ff <= wdat[15:12];
         // top drive bit also clears on local reset
         if (local_reset)
            drive_ff[3] <= 1'b0;
      end
   end

   // drive only where direction says output
   assign gp_pin_oe  = dir_ff;
   assign gp_pin_out = drive_ff;

   // ---------------------------------------------------------------
   // input filters
   // ---------------------------------------------------------------
   // grant and request filter bypass
   assign filt_bypass = {~misc_ff[`ILV_MISC_IRQFILT], {6{~misc_ff[`ILV_MISC_IRQFILT]}},
                         misc_ff[`ILV_MISC_BGOFF]};

   ilv_filt #(
      .W      (8)
   ) u_filt (
      .clock  (clock),
      .rst    (rst),
      .din    ({bp_req, bgin_raw}),
      .bypass (filt_bypass),
      .dout   (filt_out)
   );

   assign bgin_clean = filt_out[0];
   // spare request is not filtered
   assign req_filt   = {spare_req, filt_out[7:1]};

   // ---------------------------------------------------------------
   // sticky status
   // ---------------------------------------------------------------
   // set wins over a one written to clear in the same cycle
   always @* begin
      nxt_stat = stat_ff;
      if (wr_stat)
         nxt_stat = stat_ff & ~(wdat[13:0] & wmask[13:0]);
      if (wr_set)
         nxt_stat[5:0] = nxt_stat[5:0] | (wdat[5:0] & wmask[5:0]);
      nxt_stat[13:6] = nxt_stat[13:6] | (req_filt & ~req_prev_ff);
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         stat_ff     <= `ILV_RST_SRC;
         req_prev_ff <= 8'h00;
      end else if (clr_psl) begin
         stat_ff     <= `ILV_RST_SRC;
         req_prev_ff <= req_filt;
      end else begin
         stat_ff     <= nxt_stat;
         req_prev_ff <= req_filt;
      end
   end

   // ---------------------------------------------------------------
   // interrupt presentation
   // ---------------------------------------------------------------
   // global unmask gates every source
   assign pend = global_irq_unmask_ff ? (stat_ff & mask_ff) : `ILV_RST_SRC;
   assign irq  = |pend;

   always @* begin
      nxt_level = 3'h0;
      for (i = 0; i < `ILV_NUM_SRC; i = i + 1) begin
         if (pend[i] && (ilv_src_lvl(i[3:0], soft_lvl_ff, bp_lvl_ff) > nxt_level))
            nxt_level = ilv_src_lvl(i[3:0], soft_lvl_ff, bp_lvl_ff);
      end
   end

   always @(posedge clock or posedge rst) begin
      if (rst)
         local_level <= 3'h0;
      else
         local_level <= nxt_level;
   end

   assign vector_base_zero = vec_ff[7:4];
   assign vector_base_one  = vec_ff[3:0];

   // ---------------------------------------------------------------
   // bus busy hold
   // ---------------------------------------------------------------
   // hold length picked by short hold bit
   always @(posedge clock or posedge rst) begin
      if (rst)
         bsy_cnt_ff <= 6'h00;
      else if (bp_won & local_retried)
         bsy_cnt_ff <= misc_ff[`ILV_MISC_SHORTBSY] ? `ILV_BSY_SHORT : `ILV_BSY_LONG;
      else if (bsy_cnt_ff != 6'h00)
         bsy_cnt_ff <= bsy_cnt_ff - 6'h01;
   end

   // no early release follows the strobe
   assign bbsy_drive = (bsy_cnt_ff != 6'h00) |
                       (misc_ff[`ILV_MISC_NOEARLY] & as_active);

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always @* begin
      case (addr_ff)
         `ILV_OFS_SOFT_LVL: nxt_rdata = {8'h00, soft_lvl_ff};
         `ILV_OFS_BP_LVL:   nxt_rdata = bp_lvl_ff;
         `ILV_OFS_VEC_IO:   nxt_rdata = {vec_ff, global_irq_unmask_ff, sysfail_active, acfail_active,
                                         abort_active, dir_ff, drive_ff, gp_pin_in,
                                         gp_input_pins};
         `ILV_OFS_MISC:     nxt_rdata = {24'h000000, misc_ff};
         `ILV_OFS_IRQ_STAT: nxt_rdata = {18'h00000, stat_ff};
         `ILV_OFS_IRQ_MASK: nxt_rdata = {18'h00000, mask_ff};
         default:           nxt_rdata = `ILV_RST_WORD;
      endcase
   end

   // data sampled in the wait state, held until next read
   always @(posedge clock or posedge rst) begin
      if (rst)
         hrdata <= `ILV_RST_WORD;
      else if (rd_ff)
         hrdata <= nxt_rdata;
   end
endmodule // ilv_ctl

//--- verilog/ilv_filt.v
`timescale 1ns/1ps
`include "ilv_map.vh"
// ---------------------------------------------------------------
// input glitch filter, per bit bypass
// ---------------------------------------------------------------
module ilv_filt #(
   parameter W = 8
) (
   // clock and reset
   input  wire         clock,
   input  wire         rst,
   // raw and filtered lines
   input  wire [W-1:0] din,
   input  wire [W-1:0] bypass,
   output wire [W-1:0] dout
);
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         reg [1:0] cnt_ff;  // cycles the raw level has differed
         reg       filt_ff; // settled level of this bit
         // a change is taken only after it holds for the full length
         always @(posedge clock or posedge rst) begin
            if (rst) begin
               cnt_ff  <= 2'h0;
               filt_ff <= 1'b0;
            end else if (din[g] == filt_ff) begin
               cnt_ff <= 2'h0;
            end else if (cnt_ff == `ILV_FILT_LEN - 2'h1) begin
               cnt_ff  <= 2'h0;
               filt_ff <= din[g];
            end else begin
               cnt_ff <= cnt_ff + 2'h1;
            end
         end
         // bypass trades glitch immunity for latency
         assign dout[g] = bypass[g] ? din[g] : filt_ff;
      end
   endgenerate
endmodule // ilv_filt

//--- verilog/ilv_map.vh
`ifndef ILV_MAP_VH
`define ILV_MAP_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ILV_OFS_SOFT_LVL   8'h80
`define ILV_OFS_BP_LVL     8'h84
`define ILV_OFS_VEC_IO     8'h88
`define ILV_OFS_MISC       8'h8C
`define ILV_OFS_IRQ_STAT   8'h90
`define ILV_OFS_IRQ_MASK   8'h94
`define ILV_OFS_SOFT_SET   8'h98
// ---------------------------------------------------------------
// field layouts and masks
// ---------------------------------------------------------------
`define ILV_SOFT_LVL_MASK  32'h00777777
`define ILV_BP_LVL_MASK    32'h77777777
`define ILV_LVL_W          3
`define ILV_NUM_SRC        14
`define ILV_SRC_SOFT0      0
`define ILV_SRC_BP1        6
`define ILV_SRC_SPARE      13
`define ILV_BIT_GLOBAL_IRQ_UNMASK       23
`define ILV_BIT_SYSFAIL_LINE_STATE      22
`define ILV_BIT_ACFAIL_LINE_STATE       21
`define ILV_BIT_ABRT       20
`define ILV_MISC_BGOFF     0
`define ILV_MISC_IRQFILT   1
`define ILV_MISC_SHORTBSY  2
`define ILV_MISC_NOEARLY   3
// misc bits 7..5 clear on every reset, 4..0 skip local reset
`define ILV_MISC_PSL_MASK  8'hE0
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ILV_RST_WORD       32'h00000000
`define ILV_RST_BYTE       8'h00
`define ILV_RST_SRC        14'h0000
// ---------------------------------------------------------------
// timing counts in local clocks
// ---------------------------------------------------------------
`define ILV_BSY_LONG       6'h20
`define ILV_BSY_SHORT      6'h03
`define ILV_FILT_LEN       2'h3
`endif
